// *** cci_pkg.sv ***
// shared constants and types for the comparator change interrupt block
`default_nettype none

package cci_pkg;

  // bus and register geometry
  localparam int unsigned CCI_ADDR_W = 8;
  localparam int unsigned CCI_DATA_W = 32;
  localparam int unsigned CCI_NCMP   = 2;

  // register byte offsets
  localparam logic [7:0] CCI_OFS_CTRL0  = 8'h00;
  localparam logic [7:0] CCI_OFS_CTRL1  = 8'h04;
  localparam logic [7:0] CCI_OFS_AUX    = 8'h08;
  localparam logic [7:0] CCI_OFS_INTCTL = 8'h0C;
  localparam logic [7:0] CCI_OFS_PIEN   = 8'h10;
  localparam logic [7:0] CCI_OFS_PIFLG  = 8'h14;
  localparam logic [7:0] CCI_OFS_EVST   = 8'h18;
  localparam logic [7:0] CCI_OFS_EVMSK  = 8'h1C;

  // comparator_control_reg fields
  localparam int unsigned CCI_CTL_OUT_BIT = 0;
  localparam int unsigned CCI_CTL_POL_BIT = 1;
  localparam int unsigned CCI_CTL_OE_BIT  = 2;
  localparam int unsigned CCI_CTL_EN_BIT  = 3;

  // comparator_aux_control_reg fields
  localparam int unsigned CCI_AUX_GATE_BIT = 0;
  localparam int unsigned CCI_AUX_OUT1_BIT = 1;
  localparam int unsigned CCI_AUX_OUT2_BIT = 2;
  localparam int unsigned CCI_AUX_RDY1_BIT = 3;
  localparam int unsigned CCI_AUX_RDY2_BIT = 4;

  // interrupt_control fields
  localparam int unsigned CCI_GIE_BIT  = 7;
  localparam int unsigned CCI_PERIPHERAL_IRQ_ENABLE_BIT = 6;

  // peripheral flag and enable fields
  localparam int unsigned CCI_C1_BIT = 3;
  localparam int unsigned CCI_C2_BIT = 4;
  localparam logic [7:0]  CCI_PI_IMPL = 8'h7B;

  // event status fields: flag-set events, then lost edges
  localparam int unsigned CCI_EV_SET0_BIT  = 0;
  localparam int unsigned CCI_EV_LOST0_BIT = 2;
  localparam int unsigned CCI_EV_W         = 4;

  // reset values
  localparam logic [7:0] CCI_RST_INTCTL = 8'h00;
  localparam logic [7:0] CCI_RST_PIEN   = 8'h00;
  localparam logic [7:0] CCI_RST_PIFLG  = 8'h00;
  localparam logic [2:0] CCI_RST_CTRL   = 3'h0;
  localparam logic [3:0] CCI_RST_EV     = 4'h0;

  // timing: comparator bias settling
  localparam int unsigned CCI_CLK_PERIOD_NS = 40;
  localparam int unsigned CCI_SETTLE_NS     = 1000;
  localparam int unsigned CCI_SETTLE_CYC    =
    (CCI_SETTLE_NS + CCI_CLK_PERIOD_NS - 1) / CCI_CLK_PERIOD_NS;
  localparam int unsigned CCI_SETTLE_W      = 5;
  localparam logic [CCI_SETTLE_W-1:0] CCI_SETTLE_MAX =
    CCI_SETTLE_W'(CCI_SETTLE_CYC);

  // quarter phases of the system clock, gray ordered
  typedef enum logic [1:0] {
    CCI_PH1 = 2'h0,
    CCI_PH2 = 2'h1,
    CCI_PH3 = 2'h3,
    CCI_PH4 = 2'h2
  } cci_phase_e;

endpackage : cci_pkg

`default_nettype wire

// *** cci_change_det.sv ***
// per-comparator input sync, mismatch latches and change edge detect
`default_nettype none

module cci_change_det
  import cci_pkg::*;
(
  // clock, reset, enable
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  // comparator side
  input  wire logic cmp_above,
  input  wire logic enable,
  input  wire logic polarity,
  // timing and register access
  input  wire logic phase_one,
  input  wire logic ctrl_read,
  // results
  output logic      cmp_level,
  output logic      sampled,
  output logic      mismatch,
  output logic      edge_set,
  output logic      edge_lost,
  output logic      settled
);

  logic [2:0]              sync_q;
  logic                    filt_q;
  logic                    capture_q;
  logic                    next_sample;
  logic                    next_capture;
  logic                    next_mismatch;
  logic                    rise;
  logic [CCI_SETTLE_W-1:0] settle_cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_q <= 3'h0;
    end else if (ce) begin
      sync_q <= {sync_q[1:0], cmp_above};
    end
  end

  // level moves only once second and third stage agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_q <= 1'b0;
    end else if (ce && (sync_q[1] == sync_q[2])) begin
      filt_q <= sync_q[2];
    end
  end

  // high while noninverting input is above inverting input, inverted when polarity is set, low while not enabled
  assign cmp_level = enable & (filt_q ^ polarity);

  assign next_sample   = phase_one ? cmp_level : sampled;
  assign next_capture  = ctrl_read ? cmp_level : capture_q;
  assign next_mismatch = next_sample ^ next_capture;
  assign rise          = next_mismatch & ~mismatch;
  // an edge meeting a control read is dropped
  assign edge_set      = rise & ~ctrl_read;
  assign edge_lost     = rise & ctrl_read;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sampled   <= 1'b0;
      capture_q <= 1'b0;
      mismatch  <= 1'b0;
    end else if (ce) begin
      sampled   <= next_sample;
      capture_q <= next_capture;
      mismatch  <= next_mismatch;
    end
  end

  // bias settling time after enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_cnt <= '0;
    end else if (ce) begin
      if (!enable) begin
        settle_cnt <= '0;
      end else if (settle_cnt != CCI_SETTLE_MAX) begin
        settle_cnt <= settle_cnt + CCI_SETTLE_W'(1);
      end
    end
  end

  assign settled = (settle_cnt == CCI_SETTLE_MAX);

endmodule : cci_change_det

`default_nettype wire

// *** cci_top.sv ***
// comparator change detect and interrupt block with apb registers
//
// Chosen here: the APB slave port and the register offsets.
`default_nettype none

// Summary of operation
// - comparator output high when noninverting above inverting, else low.
// - control register read loads capture latch; it holds until next read.
// - sampling latch takes comparator output on every first quarter phase.
// - mismatch is the exclusive-or of the capture and sampling latches.
// - mismatch stays until control read or output returns to prior level.
// - a control register write also reloads capture, clearing mismatch.
// - flag sets on mismatch rising edge, so it clears without mismatch.
// - after a clearing access, return to earlier level raises a new flag.
// - detection and flagging do not depend on pin drive enable.
// - software writing one to the flag sets it and requests interrupt.
// - request reaches core only with own, peripheral and global enables; irq also rises on any event status bit set in ev_mask, without them.
// - flag still sets on mismatch edge with any enable cleared.
// - change meeting a control read in second phase may lose the flag.
// - only the second comparator can drive the gated counter gate.
module cci_top
  import cci_pkg::*;
(
  // clock, reset, clock enable
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  ce,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [CCI_ADDR_W-1:0] paddr,
  input  wire logic [CCI_DATA_W-1:0] pwdata,
  output logic      [CCI_DATA_W-1:0] prdata,
  output logic                       pready,
  output logic                       pslverr,
  // comparator results, high while noninverting is above inverting
  input  wire logic [CCI_NCMP-1:0]   cmp_above,
  // comparator output pins
  output logic      [CCI_NCMP-1:0]   cmp_pin_out,
  output logic      [CCI_NCMP-1:0]   cmp_pin_oe,
  // gated counter gate
  output logic                       gated_counter_gate,
  // interrupt request
  output logic                       irq
);

  cci_phase_e phase;
  cci_phase_e next_phase;

  logic [CCI_NCMP-1:0] ctl_pol;
  logic [CCI_NCMP-1:0] ctl_oe;
  logic [CCI_NCMP-1:0] ctl_en;
  logic                aux_gate_route;
  logic [7:0]          interrupt_control;
  logic [7:0]          peripheral_irq_enable_reg;
  logic [7:0]          peripheral_irq_flag_reg;
  logic [CCI_EV_W-1:0] ev_status;
  logic [CCI_EV_W-1:0] ev_mask;

  logic                  access;
  logic                  wr_acc;
  logic                  rd_acc;
  logic                  addr_ok;
  logic [CCI_NCMP-1:0]   ctrl_hit;
  logic [CCI_NCMP-1:0]   ctrl_read;
  logic [CCI_NCMP-1:0]   cmp_level;
  logic [CCI_NCMP-1:0]   sampled;
  logic [CCI_NCMP-1:0]   mismatch;
  logic [CCI_NCMP-1:0]   edge_set;
  logic [CCI_NCMP-1:0]   edge_lost;
  logic [CCI_NCMP-1:0]   settled;
  logic [7:0]            hw_flag_set;
  logic [7:0]            next_pir;
  logic [CCI_EV_W-1:0]   ev_in;
  logic [CCI_EV_W-1:0]   next_ev;
  logic [CCI_DATA_W-1:0] rd_data;
  logic                  doc_req;

  // quarter-phase sequencer of the system clock
  always_comb begin
    case (phase)
      CCI_PH1: next_phase = CCI_PH2;
      CCI_PH2: next_phase = CCI_PH3;
      CCI_PH3: next_phase = CCI_PH4;
      CCI_PH4: next_phase = CCI_PH1;
      default: next_phase = CCI_PH1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= CCI_PH1;
    end else if (ce) begin
      phase <= next_phase;
    end
  end

  // apb decode; transfer completes on the edge where pready is seen high
  assign access  = ce & psel & penable & pready;
  assign wr_acc  = access & pwrite;
  assign rd_acc  = access & ~pwrite;

  always_comb begin
    case (paddr)
      CCI_OFS_CTRL0,
      CCI_OFS_CTRL1,
      CCI_OFS_AUX,
      CCI_OFS_INTCTL,
      CCI_OFS_PIEN,
      CCI_OFS_PIFLG,
      CCI_OFS_EVST,
      CCI_OFS_EVMSK: addr_ok = 1'b1;
      default:       addr_ok = 1'b0;
    endcase
  end

  assign ctrl_hit[0] = (paddr == CCI_OFS_CTRL0);
  assign ctrl_hit[1] = (paddr == CCI_OFS_CTRL1);
  // every control register access, write included, reads that register first
  assign ctrl_read   = {CCI_NCMP{access}} & ctrl_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else if (ce) begin
      pready <= psel & penable & ~pready;
    end
  end

  // per-comparator change detectors
  genvar gi;
  generate
    for (gi = 0; gi < CCI_NCMP; gi++) begin : g_cmp
      cci_change_det u_det (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (ce),
        .cmp_above (cmp_above[gi]),
        .enable    (ctl_en[gi]),
        .polarity  (ctl_pol[gi]),
        .phase_one (phase == CCI_PH1),
        .ctrl_read (ctrl_read[gi]),
        .cmp_level (cmp_level[gi]),
        .sampled   (sampled[gi]),
        .mismatch  (mismatch[gi]),
        .edge_set  (edge_set[gi]),
        .edge_lost (edge_lost[gi]),
        .settled   (settled[gi])
      );
    end
  endgenerate

  // comparator_control_reg writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_pol <= CCI_RST_CTRL[CCI_NCMP-1:0];
      ctl_oe  <= CCI_RST_CTRL[CCI_NCMP-1:0];
      ctl_en  <= CCI_RST_CTRL[CCI_NCMP-1:0];
    end else begin
      for (int i = 0; i < CCI_NCMP; i++) begin
        if (wr_acc && ctrl_hit[i]) begin
          ctl_pol[i] <= pwdata[CCI_CTL_POL_BIT];
          ctl_oe[i]  <= pwdata[CCI_CTL_OE_BIT];
          ctl_en[i]  <= pwdata[CCI_CTL_EN_BIT];
        end
      end
    end
  end

  // comparator_aux_control_reg
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_gate_route <= 1'b0;
    end else if (wr_acc && (paddr == CCI_OFS_AUX)) begin
      aux_gate_route <= pwdata[CCI_AUX_GATE_BIT];
    end
  end

  // interrupt_control and peripheral_irq_enable_reg
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_control         <= CCI_RST_INTCTL;
      peripheral_irq_enable_reg <= CCI_RST_PIEN;
    end else if (wr_acc) begin
      if (paddr == CCI_OFS_INTCTL) begin
        interrupt_control <= pwdata[7:0];
      end
      if (paddr == CCI_OFS_PIEN) begin
        peripheral_irq_enable_reg <= pwdata[7:0] & CCI_PI_IMPL;
      end
    end
  end

  // flags set regardless of any enable
  always_comb begin
    hw_flag_set             = 8'h00;
    hw_flag_set[CCI_C1_BIT] = edge_set[0];
    hw_flag_set[CCI_C2_BIT] = edge_set[1];
  end

  // written value is stored masked to the implemented bits, so zero clears and one sets
  always_comb begin
    next_pir = peripheral_irq_flag_reg;
    if (wr_acc && (paddr == CCI_OFS_PIFLG)) begin
      next_pir = pwdata[7:0] & CCI_PI_IMPL;
    end
    // a hardware edge wins over a same-cycle clear
    next_pir = next_pir | hw_flag_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peripheral_irq_flag_reg <= CCI_RST_PIFLG;
    end else if (ce) begin
      peripheral_irq_flag_reg <= next_pir;
    end
  end

  // event status: flag-set events and edges lost to a control read
  assign ev_in = {edge_lost, edge_set};

  always_comb begin
    next_ev = ev_status;
    if (wr_acc && (paddr == CCI_OFS_EVST)) begin
      next_ev = ev_status & ~pwdata[CCI_EV_W-1:0];
    end
    next_ev = next_ev | ev_in;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_status <= CCI_RST_EV;
      ev_mask   <= CCI_RST_EV;
    end else if (ce) begin
      ev_status <= next_ev;
      if (wr_acc && (paddr == CCI_OFS_EVMSK)) begin
        ev_mask <= pwdata[CCI_EV_W-1:0];
      end
    end
  end

  // read data mux
  always_comb begin
    rd_data = '0;
    case (paddr)
      CCI_OFS_CTRL0,
      CCI_OFS_CTRL1: begin
        for (int i = 0; i < CCI_NCMP; i++) begin
          if (ctrl_hit[i]) begin
            rd_data[CCI_CTL_OUT_BIT] = cmp_level[i];
            rd_data[CCI_CTL_POL_BIT] = ctl_pol[i];
            rd_data[CCI_CTL_OE_BIT]  = ctl_oe[i];
            rd_data[CCI_CTL_EN_BIT]  = ctl_en[i];
          end
        end
      end
      CCI_OFS_AUX: begin
        rd_data[CCI_AUX_GATE_BIT] = aux_gate_route;
        rd_data[CCI_AUX_OUT1_BIT] = cmp_level[0];
        rd_data[CCI_AUX_OUT2_BIT] = cmp_level[1];
        rd_data[CCI_AUX_RDY1_BIT] = settled[0];
        rd_data[CCI_AUX_RDY2_BIT] = settled[1];
      end
      CCI_OFS_INTCTL: rd_data[7:0] = interrupt_control;
      CCI_OFS_PIEN:   rd_data[7:0] = peripheral_irq_enable_reg;
      CCI_OFS_PIFLG:  rd_data[7:0] = peripheral_irq_flag_reg;
      CCI_OFS_EVST:   rd_data[CCI_EV_W-1:0] = ev_status;
      CCI_OFS_EVMSK:  rd_data[CCI_EV_W-1:0] = ev_mask;
      default:        rd_data = '0;
    endcase
  end

  // answer registered together with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (ce) begin
      if (psel && penable && !pready) begin
        prdata  <= pwrite ? '0 : rd_data;
        pslverr <= ~addr_ok;
      end else begin
        prdata  <= '0;
        pslverr <= 1'b0;
      end
    end
  end

  // core request needs own, peripheral and global enables
  assign doc_req = interrupt_control[CCI_GIE_BIT]
                 & interrupt_control[CCI_PERIPHERAL_IRQ_ENABLE_BIT]
                 & |(peripheral_irq_flag_reg & peripheral_irq_enable_reg
                     & ((8'h01 << CCI_C1_BIT) | (8'h01 << CCI_C2_BIT)));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= doc_req | |(ev_status & ev_mask);
    end
  end

  // pin drivers; detection ignores the drive enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_pin_out <= '0;
      cmp_pin_oe  <= '0;
    end else if (ce) begin
      cmp_pin_out <= cmp_level;
      cmp_pin_oe  <= ctl_oe;
    end
  end

  // only the second comparator reaches the counter gate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gated_counter_gate <= 1'b0;
    end else if (ce) begin
      gated_counter_gate <= aux_gate_route & cmp_level[1];
    end
  end

endmodule : cci_top

`default_nettype wire

// *** cci_cmp_model.sv ***
// behavioural model of the two analog comparators feeding the block
`default_nettype none

module cci_cmp_model
  import cci_pkg::*;
(
  // analog levels, one byte per comparator
  input  wire logic [CCI_NCMP-1:0][7:0] vpos,
  input  wire logic [CCI_NCMP-1:0][7:0] vneg,
  // digital results
  output logic      [CCI_NCMP-1:0]      cmp_above
);
  timeunit 1ns;
  timeprecision 1ns;

  // high only while the noninverting level is strictly above
  always_comb begin
    for (int i = 0; i < CCI_NCMP; i++) begin
      cmp_above[i] = vpos[i] > vneg[i];
    end
  end
endmodule : cci_cmp_model

`default_nettype wire

// *** cci_top_monitor.sv ***
// concurrent checks on the ports of the comparator interrupt block
`default_nettype none

module cci_top_monitor
  import cci_pkg::*;
(
  // clock, reset, enable
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  ce,
  // apb
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [CCI_ADDR_W-1:0] paddr,
  input wire logic [CCI_DATA_W-1:0] pwdata,
  input wire logic [CCI_DATA_W-1:0] prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // comparator side
  input wire logic [CCI_NCMP-1:0]   cmp_above,
  input wire logic [CCI_NCMP-1:0]   cmp_pin_out,
  input wire logic [CCI_NCMP-1:0]   cmp_pin_oe,
  input wire logic                  gated_counter_gate,
  input wire logic                  irq
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_one_cycle: assert property (pready && ce |=> !pready)
    else $error("pready stood longer than one cycle");
  a_ready_on_time: assert property (psel && penable && !pready && ce
    |=> pready) else $error("pready late after access cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle_zero: assert property (!pready |-> prdata == '0)
    else $error("prdata not zero outside answer");
  a_unmapped_err: assert property (psel && penable && pready
    && paddr > 8'h1C |-> pslverr) else $error("unmapped access no error");
  a_mapped_no_err: assert property (psel && penable && pready
    && paddr <= 8'h1C && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access flagged as error");
  // drive enable register moves at the write edge, the pin one edge later
  a_drive_after_write: assert property ($changed(cmp_pin_oe)
    |-> $past(psel && penable && pready && pwrite, 2))
    else $error("pin drive enable moved without a write");
  a_gate_second_only: assert property (
    gated_counter_gate |-> cmp_pin_out[1])
    else $error("gate high while second comparator low");
  a_ce_freeze: assert property (!ce |=> $stable(pready) && $stable(irq)
    && $stable(cmp_pin_oe)) else $error("state moved while ce low");
endmodule : cci_top_monitor

bind cci_top cci_top_monitor cci_top_monitor_i (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cmp_above(cmp_above), .cmp_pin_out(cmp_pin_out),
  .cmp_pin_oe(cmp_pin_oe), .gated_counter_gate(gated_counter_gate),
  .irq(irq)
);

`default_nettype wire

// *** cci_top_tb.sv ***
// register-level testbench for the comparator change interrupt block
`default_nettype none

module cci_top_tb
  import cci_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic                          pclk, presetn, ce, psel, penable, pwrite;
  logic                          pready, pslverr, gated_counter_gate, irq;
  logic                          err;
  logic [CCI_ADDR_W-1:0]         paddr;
  logic [CCI_DATA_W-1:0]         pwdata, prdata, d;
  logic [CCI_NCMP-1:0]           cmp_above, cmp_pin_out, cmp_pin_oe;
  logic [CCI_NCMP-1:0][7:0]      vpos, vneg;
  int                            fail_count, n_tests;

  cci_top cci_top_i (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp_above(cmp_above), .cmp_pin_out(cmp_pin_out),
    .cmp_pin_oe(cmp_pin_oe), .gated_counter_gate(gated_counter_gate),
    .irq(irq)
  );
  cci_cmp_model cci_cmp_model_i (
    .vpos(vpos), .vneg(vneg), .cmp_above(cmp_above)
  );

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task complete_run;
    if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // one apb transfer; holds the request until pready is seen high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    d   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] v);
    apb(1'b1, a, v);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(d, exp);
  endtask : rd

  task irq_is(input logic e);
    cyc(2);
    check({31'h0, irq}, {31'h0, e});
  endtask : irq_is

  // long enough for input sync plus one full phase rotation
  task setc(input int c, input logic v);
    vpos[c] <= v ? 8'hA0 : 8'h40;
    cyc(12);
  endtask : setc

  initial begin
    fail_count = 0;
    n_tests    = 0;
    presetn = 1'b0;
    ce      = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    vpos    = {8'h40, 8'h40};
    vneg    = {8'h80, 8'h80};
    cyc(12);
    presetn <= 1'b1;
    cyc(1);
    rd(CCI_OFS_INTCTL, 32'h0);
    rd(CCI_OFS_PIEN, 32'h0);
    rd(CCI_OFS_PIFLG, 32'h0);
    rd(CCI_OFS_EVST, 32'h0);
    wr(CCI_OFS_PIEN, 32'hFF);
    rd(CCI_OFS_PIEN, 32'h7B);
    wr(CCI_OFS_PIEN, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    check({31'h0, err}, 32'h1);
    check(d, 32'h0);
    // enable both, drive pin of the second, settle, then clean up
    wr(CCI_OFS_CTRL0, 32'h8);
    wr(CCI_OFS_CTRL1, 32'hC);
    cyc(30);
    rd(CCI_OFS_CTRL0, 32'h8);
    rd(CCI_OFS_CTRL1, 32'hC);
    wr(CCI_OFS_PIFLG, 32'h0);
    setc(0, 1'b1);
    rd(CCI_OFS_PIFLG, 32'h8);
    irq_is(1'b0);
    rd(CCI_OFS_CTRL0, 32'h9);
    wr(CCI_OFS_PIFLG, 32'h0);
    setc(0, 1'b0);
    rd(CCI_OFS_PIFLG, 32'h8);
    wr(CCI_OFS_PIFLG, 32'h0);
    cyc(8);
    rd(CCI_OFS_PIFLG, 32'h0);
    setc(0, 1'b1);
    rd(CCI_OFS_PIFLG, 32'h0);
    setc(0, 1'b0);
    rd(CCI_OFS_PIFLG, 32'h8);
    wr(CCI_OFS_PIFLG, 32'h0);
    wr(CCI_OFS_CTRL0, 32'h8);
    setc(0, 1'b1);
    rd(CCI_OFS_PIFLG, 32'h8);
    wr(CCI_OFS_PIFLG, 32'h0);
    check({30'h0, cmp_pin_oe}, 32'h2);
    setc(1, 1'b1);
    rd(CCI_OFS_PIFLG, 32'h10);
    check({30'h0, cmp_pin_out}, 32'h3);
    wr(CCI_OFS_AUX, 32'h1);
    cyc(2);
    check({31'h0, gated_counter_gate}, 32'h1);
    rd(CCI_OFS_AUX, 32'h1F);
    setc(1, 1'b0);
    check({31'h0, gated_counter_gate}, 32'h0);
    wr(CCI_OFS_PIEN, 32'h10);
    wr(CCI_OFS_INTCTL, 32'hC0);
    irq_is(1'b1);
    wr(CCI_OFS_INTCTL, 32'h80);
    irq_is(1'b0);
    wr(CCI_OFS_INTCTL, 32'h40);
    irq_is(1'b0);
    wr(CCI_OFS_INTCTL, 32'hC0);
    wr(CCI_OFS_PIEN, 32'h08);
    irq_is(1'b0);
    wr(CCI_OFS_PIEN, 32'h10);
    wr(CCI_OFS_PIFLG, 32'h0);
    irq_is(1'b0);
    wr(CCI_OFS_PIFLG, 32'h10);
    irq_is(1'b1);
    rd(CCI_OFS_PIFLG, 32'h10);
    wr(CCI_OFS_INTCTL, 32'h0);
    wr(CCI_OFS_PIFLG, 32'h0);
    // event status, mask and write-one-to-clear
    rd(CCI_OFS_EVST, 32'h3);
    wr(CCI_OFS_EVMSK, 32'h1);
    irq_is(1'b1);
    wr(CCI_OFS_EVST, 32'h1);
    irq_is(1'b0);
    rd(CCI_OFS_EVST, 32'h2);
    // second comparator rises while its control read is under way:
    // the read returns the old level, the new one is captured, no flag
    vpos[1] <= 8'hA0;
    cyc(2);
    rd(CCI_OFS_CTRL1, 32'hC);
    rd(CCI_OFS_PIFLG, 32'h0);
    rd(CCI_OFS_EVST, 32'hA);
    ce <= 1'b0;
    cyc(4);
    ce <= 1'b1;
    cyc(1);
    complete_run();
  end

  initial begin
    repeat (5000) @(posedge pclk);
    fail_count++;
    complete_run();
  end
endmodule : cci_top_tb

`default_nettype wire
